//--- rtl/bfe_pkg.sv
// Constants, enums and decode helpers for the bit, flag and load/store unit
package bfe_pkg;

	// ****************************************
	// Widths and register map
	// ****************************************
	localparam int unsigned DW        = 8;
	localparam int unsigned AW        = 16;
	localparam logic [5:0] RF_OFS     = 6'h00;
	localparam logic [5:0] RF_LAST    = 6'h1F;
	localparam logic [5:0] FLAG_OFS   = 6'h20;
	localparam logic [5:0] STAT_OFS   = 6'h21;
	localparam logic [7:0] FLAG_RST   = 8'h00;
	localparam logic [7:0] STAT_BUSY  = 8'h01;

	// ****************************************
	// Flag positions in the processor flag register
	// ****************************************
	localparam logic [2:0] FLG_C = 3'h0;
	localparam logic [2:0] FLG_Z = 3'h1;
	localparam logic [2:0] FLG_N = 3'h2;
	localparam logic [2:0] FLG_V = 3'h3;
	localparam logic [2:0] FLG_S = 3'h4;
	localparam logic [2:0] FLG_H = 3'h5;
	localparam logic [2:0] FLG_T = 3'h6;
	localparam logic [2:0] FLG_I = 3'h7;

	// ****************************************
	// Pointer pairs (low byte index) and timing
	// ****************************************
	localparam logic [4:0] PTR_X_LO   = 5'h1A;
	localparam logic [4:0] PTR_Y_LO   = 5'h1C;
	localparam logic [4:0] PTR_Z_LO   = 5'h1E;
	localparam int unsigned MEM_CYCLES = 2;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [4:0] {
		no_op,
		rotate_right_carry_op,
		arith_shift_right_op,
		swap_nibble_op,
		generic_flag_set_op,
		generic_flag_clear_op,
		bit_to_transfer_flag_op,
		transfer_flag_to_bit_op,
		reg_move_op,
		word_copy_op,
		immediate_load_op,
		indirect_load_op,
		displaced_load_op,
		direct_load_op,
		indirect_store_op,
		displaced_store_op,
		direct_store_op
	} bfe_op_e;

	typedef enum logic [1:0] {bfe_ptr_x, bfe_ptr_y, bfe_ptr_z} bfe_ptr_e;
	typedef enum logic [1:0] {bfe_plain, bfe_post_inc, bfe_pre_dec} bfe_mode_e;

	function automatic logic bfe_is_load(input bfe_op_e op);
		return op == indirect_load_op || op == displaced_load_op ||
			op == direct_load_op;
	endfunction

	function automatic logic bfe_is_store(input bfe_op_e op);
		return op == indirect_store_op || op == displaced_store_op ||
			op == direct_store_op;
	endfunction

	function automatic logic [4:0] bfe_ptr_lo(input bfe_ptr_e p);
		case (p)
			bfe_ptr_x: return PTR_X_LO;
			bfe_ptr_y: return PTR_Y_LO;
			default:   return PTR_Z_LO;
		endcase
	endfunction

endpackage

//--- rtl/bfe_shift_unit.sv
// Rotate, arithmetic shift and nibble swap with their flag results
`timescale 1ns/1ps
`default_nettype none
module bfe_shift_unit
	import bfe_pkg::*;
(
	input  wire bfe_op_e     op,     // Operation selector
	input  wire logic [7:0]  val,    // Operand
	input  wire logic        cin,    // Current carry
	output logic      [7:0]  res,    // Result
	output logic             c_out,  // New carry
	output logic             z_out,  // New zero
	output logic             n_out,  // New negative
	output logic             v_out   // New overflow
);

	always_comb begin
		case (op)
			rotate_right_carry_op: res = {cin, val[7:1]};
			arith_shift_right_op:  res = {val[7], val[7:1]};
			swap_nibble_op:        res = {val[3:0], val[7:4]};
			default:               res = val;
		endcase
		c_out = val[0];
		n_out = res[7];
		z_out = (res == 8'h00);
		// Overflow is N xor C after the shift
		v_out = res[7] ^ val[0];
	end

endmodule
`default_nettype wire

//--- rtl/bfe_exec.sv
// Execution unit for bit, flag and load/store instructions
`timescale 1ns/1ps
`default_nettype none
module bfe_exec
	import bfe_pkg::*;
(
	input  wire logic          clk,           // 50 MHz core clock
	input  wire logic          arst_n,        // Async reset, active low
	input  wire logic          instr_valid,   // Instruction offered
	input  wire bfe_op_e       instr_op,      // Operation
	input  wire logic [4:0]    instr_rd,      // Destination register
	input  wire logic [4:0]    instr_rr,      // Source register
	input  wire logic [2:0]    instr_bit,     // Bit or flag index
	input  wire bfe_ptr_e      instr_ptr,     // Pointer pair select
	input  wire bfe_mode_e     instr_mode,    // Pointer update mode
	input  wire logic [7:0]    instr_k,       // Immediate or displacement
	input  wire logic [15:0]   instr_addr,    // Direct address
	output logic               instr_ready,   // Unit can take an op
	input  wire logic [5:0]    reg_addr,      // Register port address
	input  wire logic [7:0]    reg_wdata,     // Register port write data
	input  wire logic          reg_wr,        // Write strobe
	input  wire logic          reg_rd,        // Read strobe
	output logic      [7:0]    reg_rdata,     // Read data, next cycle
	output logic      [15:0]   dm_addr,       // Data memory address
	output logic      [7:0]    dm_wdata,      // Data memory write data
	output logic               dm_we,         // Data memory write
	output logic               dm_re,         // Data memory read
	input  wire logic [7:0]    dm_rdata,      // Read data, cycle after dm_re
	output logic      [7:0]    flags          // Processor flag register
);

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [1:0] {st_idle, st_mem, st_wb} bfe_state_e;

	bfe_state_e  state_q;
	bfe_state_e  state_d;
	logic [7:0]  rf [32];
	logic [7:0]  flags_q;
	logic        ready_q;
	logic        ld_q;
	logic [4:0]  ld_rd_q;
	logic [7:0]  rdata_q;
	logic [15:0] dm_addr_q;
	logic [7:0]  dm_wdata_q;
	logic        dm_we_q;
	logic        dm_re_q;
	logic        acc;
	logic [4:0]  plo;
	logic [15:0] ptr_val;
	logic [15:0] ptr_new;
	logic [15:0] mem_addr;
	logic        ptr_upd;
	logic [7:0]  sh_res;
	logic        sh_c;
	logic        sh_z;
	logic        sh_n;
	logic        sh_v;

	assign acc = instr_valid && ready_q;

	bfe_shift_unit u_shift (
		.op    (instr_op),
		.val   (rf[instr_rd]),
		.cin   (flags_q[FLG_C]),
		.res   (sh_res),
		.c_out (sh_c),
		.z_out (sh_z),
		.n_out (sh_n),
		.v_out (sh_v)
	);

	// ****************************************
	// Address generation
	// ****************************************
	always_comb begin
		plo     = bfe_ptr_lo(instr_ptr);
		ptr_val = {rf[plo | 5'h01], rf[plo]};
		ptr_upd = (instr_op == indirect_load_op ||
			instr_op == indirect_store_op) && instr_mode != bfe_plain;
		case (instr_mode)
			bfe_post_inc: ptr_new = ptr_val + 16'h0001;
			bfe_pre_dec:  ptr_new = ptr_val - 16'h0001;
			default:      ptr_new = ptr_val;
		endcase
		case (instr_op)
			direct_load_op, direct_store_op:
				mem_addr = instr_addr;
			displaced_load_op, displaced_store_op:
				mem_addr = ptr_val + {8'h00, instr_k};
			default:
				// Pre-decrement addresses the new pointer value
				mem_addr = (instr_mode == bfe_pre_dec) ? ptr_new : ptr_val;
		endcase
	end

	// ****************************************
	// Sequencing of two-cycle memory ops
	// ****************************************
	always_comb begin
		case (state_q)
			st_idle: state_d = (acc && (bfe_is_load(instr_op) ||
				bfe_is_store(instr_op))) ? st_mem : st_idle;
			st_mem:  state_d = st_wb;
			st_wb:   state_d = st_idle;
			default: state_d = st_idle;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= st_idle;
			ready_q <= 1'b1;
			ld_q    <= 1'b0;
			ld_rd_q <= 5'h00;
		end else begin
			state_q <= state_d;
			ready_q <= (state_d == st_idle);
			if (acc) begin
				ld_q    <= bfe_is_load(instr_op);
				ld_rd_q <= instr_rd;
			end
		end
	end

	// ****************************************
	// Data memory port
	// ****************************************
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dm_addr_q  <= 16'h0000;
			dm_wdata_q <= 8'h00;
			dm_we_q    <= 1'b0;
			dm_re_q    <= 1'b0;
		end else begin
			dm_re_q <= acc && bfe_is_load(instr_op);
			dm_we_q <= acc && bfe_is_store(instr_op);
			if (acc && (bfe_is_load(instr_op) || bfe_is_store(instr_op))) begin
				dm_addr_q  <= mem_addr;
				dm_wdata_q <= rf[instr_rr];
			end
		end
	end

	// ****************************************
	// Register file; core writes win over port writes
	// ****************************************
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int i = 0; i < 32; i++) begin
				rf[i] <= 8'h00;
			end
		end else begin
			if (reg_wr && reg_addr <= RF_LAST) begin
				rf[reg_addr[4:0]] <= reg_wdata;
			end
			if (acc) begin
				case (instr_op)
					rotate_right_carry_op, arith_shift_right_op,
					swap_nibble_op:
						rf[instr_rd] <= sh_res;
					transfer_flag_to_bit_op:
						rf[instr_rd][instr_bit] <= flags_q[FLG_T];
					reg_move_op:
						rf[instr_rd] <= rf[instr_rr];
					word_copy_op: begin
						rf[{instr_rd[4:1], 1'b0}] <= rf[{instr_rr[4:1], 1'b0}];
						rf[{instr_rd[4:1], 1'b1}] <= rf[{instr_rr[4:1], 1'b1}];
					end
					immediate_load_op:
						rf[instr_rd] <= instr_k;
					default: begin
						if (ptr_upd) begin
							rf[plo]         <= ptr_new[7:0];
							rf[plo | 5'h01] <= ptr_new[15:8];
						end
					end
				endcase
			end
			// Memory answers the cycle after the read strobe
			if (state_q == st_wb && ld_q) begin
				rf[ld_rd_q] <= dm_rdata;
			end
		end
	end

	// ****************************************
	// Processor flag register
	// ****************************************
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			flags_q <= FLAG_RST;
		end else begin
			if (reg_wr && reg_addr == FLAG_OFS) begin
				flags_q <= reg_wdata;
			end
			if (acc) begin
				case (instr_op)
					rotate_right_carry_op, arith_shift_right_op: begin
						flags_q[FLG_C] <= sh_c;
						flags_q[FLG_Z] <= sh_z;
						flags_q[FLG_N] <= sh_n;
						flags_q[FLG_V] <= sh_v;
					end
					generic_flag_set_op:
						flags_q[instr_bit] <= 1'b1;
					generic_flag_clear_op:
						flags_q[instr_bit] <= 1'b0;
					bit_to_transfer_flag_op:
						flags_q[FLG_T] <= rf[instr_rr][instr_bit];
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// Register port reads
	// ****************************************
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_q <= 8'h00;
		end else if (!reg_rd) begin
			rdata_q <= 8'h00;
		end else if (reg_addr <= RF_LAST) begin
			rdata_q <= rf[reg_addr[4:0]];
		end else if (reg_addr == FLAG_OFS) begin
			rdata_q <= flags_q;
		end else if (reg_addr == STAT_OFS) begin
			rdata_q <= (state_q != st_idle) ? STAT_BUSY : 8'h00;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign instr_ready = ready_q;
	assign reg_rdata   = rdata_q;
	assign dm_addr     = dm_addr_q;
	assign dm_wdata    = dm_wdata_q;
	assign dm_we       = dm_we_q;
	assign dm_re       = dm_re_q;
	assign flags       = flags_q;

	// ****************************************
	// Checks
	// ****************************************
	logic        c_acc_q;
	logic        c_busw_q;
	bfe_op_e     c_op_q;
	bfe_mode_e   c_mode_q;
	logic [4:0]  c_rd_q;
	logic [4:0]  c_plo_q;
	logic [2:0]  c_bit_q;
	logic [7:0]  c_val_q;
	logic [7:0]  c_rr_q;
	logic [7:0]  c_flg_q;
	logic [7:0]  c_k_q;
	logic [15:0] c_ptr_q;

	always_ff @(posedge clk) begin
		c_acc_q  <= acc;
		c_busw_q <= reg_wr;
		c_op_q   <= instr_op;
		c_mode_q <= instr_mode;
		c_rd_q   <= instr_rd;
		c_plo_q  <= plo;
		c_bit_q  <= instr_bit;
		c_val_q  <= rf[instr_rd];
		c_rr_q   <= rf[instr_rr];
		c_flg_q  <= flags_q;
		c_k_q    <= instr_k;
		c_ptr_q  <= ptr_val;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_q);

	sequence s_mem_busy;
		!ready_q ##1 !ready_q ##1 ready_q;
	endsequence

	a_ror_result: assert property (
		c_acc_q && c_op_q == rotate_right_carry_op |->
		rf[c_rd_q] == {c_flg_q[FLG_C], c_val_q[7:1]} &&
		flags_q[FLG_C] == c_val_q[0] && flags_q[FLG_T] == c_flg_q[FLG_T])
		else $error("rotate through carry wrong");

	a_bst_copy: assert property (
		c_acc_q && !c_busw_q && c_op_q == bit_to_transfer_flag_op |->
		flags_q[FLG_T] == c_rr_q[c_bit_q] &&
		(flags_q ^ c_flg_q) == ((c_rr_q[c_bit_q] ^ c_flg_q[FLG_T]) ?
		8'h40 : 8'h00))
		else $error("bit store to T wrong");

	a_bld_insert: assert property (
		c_acc_q && c_op_q == transfer_flag_to_bit_op |->
		rf[c_rd_q][c_bit_q] == c_flg_q[FLG_T] && flags_q == c_flg_q)
		else $error("bit load from T wrong");

	a_flag_set: assert property (
		c_acc_q && !c_busw_q && c_op_q == generic_flag_set_op |->
		flags_q == (c_flg_q | (8'h01 << c_bit_q)))
		else $error("flag set touched other bits");

	a_flag_clear: assert property (
		c_acc_q && !c_busw_q && c_op_q == generic_flag_clear_op |->
		flags_q == (c_flg_q & ~(8'h01 << c_bit_q)))
		else $error("flag clear touched other bits");

	a_load_timing: assert property (
		acc && bfe_is_load(instr_op) |=> dm_re_q and s_mem_busy)
		else $error("load not two cycles");

	a_post_inc: assert property (
		c_acc_q && c_mode_q == bfe_post_inc && (c_op_q == indirect_load_op ||
		c_op_q == indirect_store_op) |->
		dm_addr_q == c_ptr_q && {rf[c_plo_q | 5'h01], rf[c_plo_q]} ==
		c_ptr_q + 16'h0001)
		else $error("post-increment wrong");

	a_pre_dec: assert property (
		c_acc_q && c_mode_q == bfe_pre_dec && (c_op_q == indirect_load_op ||
		c_op_q == indirect_store_op) |->
		dm_addr_q == c_ptr_q - 16'h0001 && {rf[c_plo_q | 5'h01],
		rf[c_plo_q]} == c_ptr_q - 16'h0001)
		else $error("pre-decrement wrong");

	a_disp_addr: assert property (
		c_acc_q && (c_op_q == displaced_load_op ||
		c_op_q == displaced_store_op) |->
		dm_addr_q == c_ptr_q + {8'h00, c_k_q} &&
		{rf[c_plo_q | 5'h01], rf[c_plo_q]} == c_ptr_q)
		else $error("displacement address wrong");

	a_store_timing: assert property (
		acc && bfe_is_store(instr_op) |=> dm_we_q && !dm_re_q ##1
		!dm_we_q ##1 ready_q)
		else $error("store not two cycles");

	a_one_cycle: assert property (
		acc && !bfe_is_load(instr_op) && !bfe_is_store(instr_op) |=>
		ready_q && !dm_we_q && !dm_re_q)
		else $error("single-cycle op stalled");

endmodule
`default_nettype wire

//--- tb/bfe_mem_model.sv
// Data memory model on the far side of the load/store port
`timescale 1ns/1ps
`default_nettype none
module bfe_mem_model (
	input  wire logic        clk,      // Core clock
	input  wire logic [15:0] dm_addr,  // Access address
	input  wire logic [7:0]  dm_wdata, // Store data
	input  wire logic        dm_we,    // Store pulse
	input  wire logic        dm_re,    // Load pulse
	output logic      [7:0]  dm_rdata  // Load data
);
	logic [7:0] mem [256];
	// One process owns both the array and the read data
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'ha5;
		end
		dm_rdata = 8'h00;
		forever begin
			@(posedge clk);
			// Only 256 bytes kept, upper address bits alias
			if (dm_we) begin
				mem[dm_addr[7:0]] <= dm_wdata;
			end
			// Data stand one cycle; inverted after so stale data never match
			if (dm_re) begin
				dm_rdata <= mem[dm_addr[7:0]];
			end else begin
				dm_rdata <= ~dm_rdata;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/bit_flag_and_load_store_exec_tb_top.sv
// Self-checking bench for the bit, flag and load/store unit
`timescale 1ns/1ps
`default_nettype none
module bit_flag_and_load_store_exec_tb_top
	import bfe_pkg::*;
;
	logic        clk, arst_n, instr_valid, instr_ready, reg_wr, reg_rd;
	logic        dm_we, dm_re;
	bfe_op_e     instr_op;
	bfe_ptr_e    instr_ptr;
	bfe_mode_e   instr_mode;
	logic [4:0]  instr_rd, instr_rr;
	logic [2:0]  instr_bit;
	logic [7:0]  instr_k, reg_wdata, reg_rdata, dm_wdata, dm_rdata, flags;
	logic [15:0] instr_addr, dm_addr;
	logic [5:0]  reg_addr;
	logic [7:0]  rf [32];
	logic [7:0]  sm [256];
	logic [7:0]  flg;
	logic [7:0]  flags_seen;
	int          mismatches, checks;

	bfe_exec dut_u (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
		.instr_op(instr_op), .instr_rd(instr_rd), .instr_rr(instr_rr),
		.instr_bit(instr_bit), .instr_ptr(instr_ptr),
		.instr_mode(instr_mode), .instr_k(instr_k),
		.instr_addr(instr_addr), .instr_ready(instr_ready),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .dm_addr(dm_addr),
		.dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re),
		.dm_rdata(dm_rdata), .flags(flags));
	bfe_mem_model mem_u (.clk(clk), .dm_addr(dm_addr),
		.dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re),
		.dm_rdata(dm_rdata));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic conclude();
		if (mismatches == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// ****************************************
	// Register port, all tasks start and end on a rising edge
	// ****************************************
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		if (a <= RF_LAST) rf[a[4:0]] = d;
		else if (a == FLAG_OFS) flg = d;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		flags_seen = flags;
		@(posedge clk);
	endtask

	task automatic chk_reg(input logic [5:0] a);
		logic [7:0] v;
		rd_reg(a, v);
		chk($sformatf("reg %h", a), 16'((a == FLAG_OFS) ? flg : rf[a[4:0]]),
			16'(v));
		if (a == FLAG_OFS) chk("flags", 16'(flg), 16'(flags_seen));
	endtask

	// ****************************************
	// Expected behaviour of one operation
	// ****************************************
	function automatic logic [15:0] model(input bfe_op_e o,
		input logic [4:0] d, r, input logic [2:0] b, input bfe_ptr_e p,
		input bfe_mode_e m, input logic [7:0] kk, input logic [15:0] a);
		logic [4:0]  lo;
		logic [15:0] pv, ea;
		logic [7:0]  v, res;
		lo = (p == bfe_ptr_x) ? PTR_X_LO :
			(p == bfe_ptr_y) ? PTR_Y_LO : PTR_Z_LO;
		pv = {rf[lo + 5'd1], rf[lo]};
		v = rf[d];
		ea = pv;
		case (o)
			no_op: ;
			rotate_right_carry_op, arith_shift_right_op: begin
				res = {(o == rotate_right_carry_op) ? flg[FLG_C] : v[7], v[7:1]};
				flg[FLG_C] = v[0];
				flg[FLG_Z] = (res == 8'h00);
				flg[FLG_N] = res[7];
				flg[FLG_V] = res[7] ^ v[0];
				rf[d] = res;
			end
			swap_nibble_op: rf[d] = {v[3:0], v[7:4]};
			generic_flag_set_op: flg[b] = 1'b1;
			generic_flag_clear_op: flg[b] = 1'b0;
			bit_to_transfer_flag_op: flg[FLG_T] = rf[r][b];
			transfer_flag_to_bit_op: rf[d][b] = flg[FLG_T];
			reg_move_op: rf[d] = rf[r];
			word_copy_op: begin
				rf[{d[4:1], 1'b0}] = rf[{r[4:1], 1'b0}];
				rf[{d[4:1], 1'b1}] = rf[{r[4:1], 1'b1}];
			end
			immediate_load_op: rf[d] = kk;
			default: begin
				if (o == direct_load_op || o == direct_store_op) ea = a;
				else if (o == displaced_load_op || o == displaced_store_op)
					ea = pv + {8'h00, kk};
				else if (m == bfe_pre_dec) begin
					pv = pv - 16'h0001;
					ea = pv;
				end else if (m == bfe_post_inc) pv = pv + 16'h0001;
				{rf[lo + 5'd1], rf[lo]} = pv;
				if (o >= indirect_store_op) sm[ea[7:0]] = rf[r];
				else rf[d] = sm[ea[7:0]];
			end
		endcase
		return ea;
	endfunction

	task automatic issue(input bfe_op_e o, input logic [4:0] d, r,
		input logic [2:0] b, input bfe_ptr_e p, input bfe_mode_e m,
		input logic [7:0] kk, input logic [15:0] a, input bit last);
		logic [15:0] ea;
		int n;
		ea = model(o, d, r, b, p, m, kk, a);
		instr_op <= o;
		{instr_rd, instr_rr, instr_bit} <= {d, r, b};
		instr_ptr <= p;
		instr_mode <= m;
		{instr_k, instr_addr} <= {kk, a};
		instr_valid <= 1'b1;
		@(posedge clk);
		if (!last) return;
		instr_valid <= 1'b0;
		#1;
		if (o >= indirect_load_op) begin
			chk("dm_re", 16'(o < indirect_store_op), 16'(dm_re));
			chk("dm_we", 16'(o >= indirect_store_op), 16'(dm_we));
			chk("dm_addr", ea, dm_addr);
			if (o >= indirect_store_op) chk("dm_wdata", 16'(sm[ea[7:0]]), 16'(dm_wdata));
		end else chk("dm_idle", 16'h0000, 16'({dm_re, dm_we}));
		n = 0;
		while (instr_ready !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1 n++;
		end
		chk("busy cycles", 16'((o >= indirect_load_op) ? 2 : 0), 16'(n));
		@(posedge clk);
	endtask

	task automatic check_state(input logic [4:0] d);
		chk_reg({1'b0, d});
		chk_reg({1'b0, d ^ 5'h01});
		for (int i = 26; i < 32; i++) chk_reg(6'(i));
		chk_reg(FLAG_OFS);
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		conclude();
	end

	initial begin
		logic [7:0] v;
		logic [4:0] d, r;
		bfe_op_e o;
		bfe_ptr_e p;
		{arst_n, instr_valid, reg_wr, reg_rd} = 4'h0;
		instr_op = no_op;
		instr_ptr = bfe_ptr_x;
		instr_mode = bfe_plain;
		{instr_rd, instr_rr, instr_bit, instr_k} = 21'h0;
		{instr_addr, reg_addr, reg_wdata} = 30'h0;
		mismatches = 0;
		checks = 0;
		flg = FLAG_RST;
		for (int i = 0; i < 256; i++) sm[i] = 8'(i) ^ 8'ha5;
		for (int i = 0; i < 32; i++) rf[i] = 8'h00;
		void'($urandom(32'h2dd4));
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk_reg(6'h00);
		chk_reg(FLAG_OFS);
		rd_reg(STAT_OFS, v);
		chk("status", 16'h0000, 16'(v));
		rd_reg(6'h22, v);
		chk("unmapped", 16'h0000, 16'(v));
		for (int i = 0; i < 33; i++) wr_reg(6'(i), 8'($urandom));
		// Pointer wrap both ways, and a load into its own pointer
		wr_reg({1'b0, PTR_Z_LO}, 8'h00);
		wr_reg({1'b0, PTR_Z_LO} + 6'h01, 8'h00);
		issue(indirect_load_op, 5'h03, 5'h00, 3'h0, bfe_ptr_z, bfe_pre_dec, 8'h00, 16'h0000, 1);
		check_state(5'h03);
		wr_reg({1'b0, PTR_X_LO}, 8'hff);
		wr_reg({1'b0, PTR_X_LO} + 6'h01, 8'hff);
		issue(indirect_store_op, 5'h00, 5'h05, 3'h0, bfe_ptr_x, bfe_post_inc, 8'h00, 16'h0000, 1);
		check_state(5'h05);
		issue(indirect_load_op, PTR_Y_LO, 5'h00, 3'h0, bfe_ptr_y, bfe_post_inc, 8'h00, 16'h0000, 1);
		check_state(PTR_Y_LO);
		// Every flag set and cleared back to back
		for (int b = 0; b < 8; b++) begin
			issue(generic_flag_set_op, 5'h00, 5'h00, 3'(b), bfe_ptr_x, bfe_plain, 8'h00, 16'h0000, 1);
			chk_reg(FLAG_OFS);
			issue(generic_flag_set_op, 5'h00, 5'h00, 3'(b), bfe_ptr_x, bfe_plain, 8'h00, 16'h0000, 0);
			issue(generic_flag_clear_op, 5'h00, 5'h00, 3'(b), bfe_ptr_x, bfe_plain, 8'h00, 16'h0000, 1);
			chk_reg(FLAG_OFS);
		end
		issue(bit_to_transfer_flag_op, 5'h00, 5'h07, 3'h5, bfe_ptr_x, bfe_plain, 8'h00, 16'h0000, 0);
		issue(transfer_flag_to_bit_op, 5'h09, 5'h00, 3'h2, bfe_ptr_x, bfe_plain, 8'h00, 16'h0000, 1);
		check_state(5'h09);
		for (int t = 0; t < 300; t++) begin
			o = bfe_op_e'($urandom_range(1, 16));
			p = bfe_ptr_e'($urandom_range(0, 2));
			d = 5'($urandom);
			r = 5'($urandom);
			if (o >= indirect_store_op && r >= 5'h1a) r = r ^ 5'h10;
			issue(o, d, r, 3'($urandom), p, bfe_mode_e'($urandom_range(0, 2)), 8'($urandom), 16'($urandom), 1);
			check_state(d);
		end
		// Reset in mid-run: outputs clear, ready stays high
		arst_n <= 1'b0;
		@(posedge clk);
		#1 chk("reset ready", 16'h0001, 16'(instr_ready));
		chk("reset flags", 16'h0000, 16'(flags));
		chk("reset rdata", 16'h0000, 16'(reg_rdata));
		chk("reset dm", 16'h0000, 16'({dm_re, dm_we}));
		@(posedge clk);
		arst_n <= 1'b1;
		flg = FLAG_RST;
		for (int i = 0; i < 32; i++) rf[i] = 8'h00;
		repeat (3) @(posedge clk);
		check_state(5'h00);
		conclude();
	end
endmodule
`default_nettype wire
